// file: tum_consts.svh
// Register offsets, field positions, reset values and timing counts for the measurement bank
`ifndef TUM_CONSTS_SVH
`define TUM_CONSTS_SVH
`define TUM_OFS_CHG_CNT 16'h2263
`define TUM_OFS_MAXF_P1 16'h2280
`define TUM_OFS_MAXF_P2 16'h2281
`define TUM_OFS_MAXF_P3 16'h2282
`define TUM_OFS_MAXF_N 16'h2283
`define TUM_OFS_RMS_P1 16'h2284
`define TUM_OFS_RMS_P2 16'h2285
`define TUM_OFS_RMS_P3 16'h2286
`define TUM_OFS_RMS_N 16'h2287
`define TUM_OFS_GF 16'h2288
`define TUM_OFS_EL 16'h2289
`define TUM_OFS_BATT 16'h228A
`define TUM_OFS_LT_HI 16'h22A0
`define TUM_OFS_LT_LO 16'h22A1
`define TUM_OFS_ROT 16'h22A7
`define TUM_OFS_LANG 16'h258D
`define TUM_OFS_FREQ 16'h258E
`define TUM_NO_FAULT 16'h8000
`define TUM_FAULT_MAX 16'h3E80
`define TUM_PCT_MAX 16'h7FFF
`define TUM_BATT_HI_MV 16'h0AF0
`define TUM_BATT_LO_MV 16'h0898
`define TUM_BATT_FULL 16'h0064
`define TUM_BATT_HALF 16'h0032
`define TUM_BATT_EMPTY 16'h0000
`define TUM_MOD_BASE 16'h2710
`define TUM_LANG_MASK 16'h03BF
`define TUM_LANG_RESET 16'h0004
`define TUM_FREQ_MASK 16'h0009
`define TUM_FREQ_RESET 16'h0001
`define TUM_FREQ_400_BIT 3
`define TUM_CLK_HZ 50000000
`define TUM_TICK_S 1
`define TUM_TICK_CYC (`TUM_CLK_HZ * `TUM_TICK_S)
`endif

// file: tum_pkg.sv
// Types shared by the measurement register bank
package tum_pkg;
  typedef logic [15:0] tum_word_t;
  typedef logic [15:0] tum_addr_t;
  typedef enum logic [1:0]
  {
    TUM_PU_WAIT = 2'b00,
    TUM_PU_BUMP = 2'b01,
    TUM_PU_RUN = 2'b10
  } tum_pu_state_t;
endpackage

// file: tum_tick.sv
// One-second enable pulse divider from the system clock
`include "tum_consts.svh"
module tum_tick #(
  parameter int unsigned TICK_CYCLES = `TUM_TICK_CYC
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // One-cycle enable
  output logic tick_out
);
  // Counter wide enough for one second at 50 MHz
  logic [25:0] cnt_q;
  logic [25:0] cnt_d;
  logic wrap;

  // Wrap at the last cycle of the period
  assign wrap = (cnt_q == 26'(TICK_CYCLES - 1));
  assign cnt_d = wrap ? 26'h0 : cnt_q + 26'h1;

  // Count and emit pulse
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= 26'h0;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_out <= wrap;
    end
  end
endmodule

// file: tum_regs.sv
// Trip unit measurement register bank with local and remote register access
`include "tum_consts.svh"
module tum_regs #(
  parameter int unsigned TICK_CYCLES = `TUM_TICK_CYC
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Register port from the serial protocol engine
  input wire tum_pkg::tum_addr_t reg_addr_in,
  input wire logic reg_wr_in,
  input wire tum_pkg::tum_word_t reg_wdata_in,
  output tum_pkg::tum_word_t reg_rdata_out,
  output logic reg_valid_out,
  // Protection manager events
  input wire logic setting_applied_in,
  input wire logic switches_changed_off_in,
  // Fault capture
  input wire logic aux_power_in,
  input wire logic breaker_code_ok_in,
  input wire logic fault_trip_in,
  input wire tum_pkg::tum_word_t fault_p1_in,
  input wire tum_pkg::tum_word_t fault_p2_in,
  input wire tum_pkg::tum_word_t fault_p3_in,
  input wire tum_pkg::tum_word_t fault_n_in,
  // Live measurements
  input wire tum_pkg::tum_word_t rms_p1_in,
  input wire tum_pkg::tum_word_t rms_p2_in,
  input wire tum_pkg::tum_word_t rms_p3_in,
  input wire tum_pkg::tum_word_t rms_n_in,
  input wire logic neutral_sensor_in,
  input wire tum_pkg::tum_word_t ground_fault_in,
  input wire tum_pkg::tum_word_t earth_leakage_in,
  input wire tum_pkg::tum_word_t battery_mv_in,
  input wire logic [31:0] lt_remaining_in,
  input wire logic rotation_acb_in,
  // Local keypad language change
  input wire logic keypad_lang_wr_in,
  input wire tum_pkg::tum_word_t keypad_lang_in,
  // Protection control
  output logic rotation_prot_en_out
);
  import tum_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Clamp to an upper range limit
  function automatic tum_word_t clamp(input tum_word_t v, input tum_word_t lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  // Split a count into high and low modulo-10000 words
  function automatic tum_word_t mod_hi(input logic [31:0] v);
    mod_hi = 16'(v / 32'(`TUM_MOD_BASE));
  endfunction

  function automatic tum_word_t mod_lo(input logic [31:0] v);
    mod_lo = 16'(v % 32'(`TUM_MOD_BASE));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Power-up sequencing

  // Power-up state, one bump slot for switch changes
  tum_pu_state_t pu_q;
  tum_pu_state_t pu_d;
  logic pu_bump;

  always_comb
  begin
    pu_d = pu_q;
    unique case (pu_q)
      // Wait one cycle after release to sample the strap
      TUM_PU_WAIT: pu_d = switches_changed_off_in ? TUM_PU_BUMP : TUM_PU_RUN;
      TUM_PU_BUMP: pu_d = TUM_PU_RUN;
      TUM_PU_RUN: pu_d = TUM_PU_RUN;
      default: pu_d = TUM_PU_RUN;
    endcase
  end

  // Single increment at power-up, only when switches changed while off
  assign pu_bump = (pu_q == TUM_PU_BUMP);

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      pu_q <= TUM_PU_WAIT;
    else
      pu_q <= pu_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setting change counter

  tum_word_t chg_cnt_q;
  tum_word_t chg_cnt_d;
  logic chg_inc;

  // Panel and comm changes arrive on one strobe
  assign chg_inc = setting_applied_in | pu_bump;
  // Wraps naturally past 65535
  assign chg_cnt_d = chg_inc ? chg_cnt_q + 16'h1 : chg_cnt_q;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      chg_cnt_q <= 16'h0;
    else
      chg_cnt_q <= chg_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Maximum fault currents

  tum_word_t fault_in [4];
  tum_word_t maxf_q [4];
  logic fault_ok;

  assign fault_in[0] = fault_p1_in;
  assign fault_in[1] = fault_p2_in;
  assign fault_in[2] = fault_p3_in;
  assign fault_in[3] = fault_n_in;
  // Capture gated by aux power and breaker code
  assign fault_ok = fault_trip_in & aux_power_in & breaker_code_ok_in;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_maxf
      tum_word_t cand;
      logic take;
      assign cand = clamp(fault_in[gi], `TUM_FAULT_MAX);
      // First fault or a larger one replaces the held value
      assign take = fault_ok & ((maxf_q[gi] == `TUM_NO_FAULT) | (cand > maxf_q[gi]));

      // Holds no-fault marker until a qualified trip
      always_ff @(posedge clock_in)
      begin
        if (!rst_n_in)
          maxf_q[gi] <= `TUM_NO_FAULT;
        else if (take)
          maxf_q[gi] <= cand;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Battery level encoding

  tum_word_t batt_lvl;
  // Three-step indicator
  assign batt_lvl = (battery_mv_in > `TUM_BATT_HI_MV) ? `TUM_BATT_FULL :
                    (battery_mv_in > `TUM_BATT_LO_MV) ? `TUM_BATT_HALF : `TUM_BATT_EMPTY;

  ////////////////////////////////////////////////////////////////////////////
  // Long-time remaining, refreshed once per second

  logic tick;
  tum_word_t lt_hi_q;
  tum_word_t lt_lo_q;

  tum_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .tick_out(tick)
  );

  // Sampled every tick regardless of any trip state
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      lt_hi_q <= 16'h0;
      lt_lo_q <= 16'h0;
    end
    else if (tick)
    begin
      lt_hi_q <= mod_hi(lt_remaining_in);
      lt_lo_q <= mod_lo(lt_remaining_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable selections

  tum_word_t lang_q;
  tum_word_t freq_q;
  logic wr_lang;
  logic wr_freq;

  assign wr_lang = reg_wr_in & (reg_addr_in == `TUM_OFS_LANG);
  assign wr_freq = reg_wr_in & (reg_addr_in == `TUM_OFS_FREQ);

  // Keypad write first, so keypad wins over a remote write in the same cycle; reserved masked
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      lang_q <= `TUM_LANG_RESET;
    else if (keypad_lang_wr_in)
      lang_q <= keypad_lang_in & `TUM_LANG_MASK;
    else if (wr_lang)
      lang_q <= reg_wdata_in & `TUM_LANG_MASK;
  end

  // Only bits 0 and 3 stored
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      freq_q <= `TUM_FREQ_RESET;
    else if (wr_freq)
      freq_q <= reg_wdata_in & `TUM_FREQ_MASK;
  end

  // Rotation protection off at 400 Hz
  assign rotation_prot_en_out = ~freq_q[`TUM_FREQ_400_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  tum_word_t rd_d;
  logic hit_d;

  // Unmapped or hidden addresses answer invalid with zero data
  always_comb
  begin
    rd_d = 16'h0;
    hit_d = 1'b1;
    unique case (reg_addr_in)
      `TUM_OFS_CHG_CNT: rd_d = chg_cnt_q;
      `TUM_OFS_MAXF_P1: rd_d = maxf_q[0];
      `TUM_OFS_MAXF_P2: rd_d = maxf_q[1];
      `TUM_OFS_MAXF_P3: rd_d = maxf_q[2];
      `TUM_OFS_MAXF_N: rd_d = maxf_q[3];
      `TUM_OFS_RMS_P1: rd_d = clamp(rms_p1_in, `TUM_PCT_MAX);
      `TUM_OFS_RMS_P2: rd_d = clamp(rms_p2_in, `TUM_PCT_MAX);
      `TUM_OFS_RMS_P3: rd_d = clamp(rms_p3_in, `TUM_PCT_MAX);
      `TUM_OFS_RMS_N:
      begin
        rd_d = neutral_sensor_in ? clamp(rms_n_in, `TUM_PCT_MAX) : 16'h0;
        hit_d = neutral_sensor_in;
      end
      `TUM_OFS_GF: rd_d = clamp(ground_fault_in, `TUM_PCT_MAX);
      `TUM_OFS_EL: rd_d = clamp(earth_leakage_in, `TUM_PCT_MAX);
      `TUM_OFS_BATT: rd_d = batt_lvl;
      `TUM_OFS_LT_HI: rd_d = lt_hi_q;
      `TUM_OFS_LT_LO: rd_d = lt_lo_q;
      `TUM_OFS_ROT: rd_d = {15'h0, rotation_acb_in};
      `TUM_OFS_LANG: rd_d = lang_q;
      `TUM_OFS_FREQ: rd_d = freq_q;
      default: hit_d = 1'b0;
    endcase
  end

  // Registered read answer, one cycle after the address
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      reg_rdata_out <= 16'h0;
      reg_valid_out <= 1'b0;
    end
    else
    begin
      reg_rdata_out <= rd_d;
      reg_valid_out <= hit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_chg_cnt_step: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    setting_applied_in && pu_q == TUM_PU_RUN |=> chg_cnt_q == $past(chg_cnt_q) + 16'h1)
    else $error("change counter did not step");

  a_chg_cnt_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !setting_applied_in && pu_q == TUM_PU_RUN |=> chg_cnt_q == $past(chg_cnt_q))
    else $error("change counter moved without event");

  a_pu_bump_once: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    pu_bump |=> !pu_bump [*4])
    else $error("power-up bump repeated");

  a_maxf_gated: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !(aux_power_in && breaker_code_ok_in) |=> maxf_q[0] == $past(maxf_q[0]))
    else $error("fault max changed without power or code");

  a_maxf_range: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    maxf_q[1] == `TUM_NO_FAULT || maxf_q[1] <= `TUM_FAULT_MAX)
    else $error("fault max out of range");

  a_batt_full: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    reg_addr_in == `TUM_OFS_BATT && battery_mv_in > `TUM_BATT_HI_MV
      |=> reg_rdata_out == `TUM_BATT_FULL)
    else $error("battery level wrong");

  a_lt_tick_only: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !tick |=> lt_lo_q == $past(lt_lo_q) && lt_hi_q == $past(lt_hi_q))
    else $error("remaining time changed off tick");

  a_lt_mod_lo: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    lt_lo_q < `TUM_MOD_BASE)
    else $error("remaining time low word out of modulo");

  a_rot_400: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wr_freq && reg_wdata_in[`TUM_FREQ_400_BIT] |=> !rotation_prot_en_out)
    else $error("rotation protection not disabled at 400 Hz");

  a_lang_rsvd: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    lang_q[15:10] == 6'h0 && !lang_q[6])
    else $error("reserved language bits set");

  a_keypad_lang: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    keypad_lang_wr_in |=> lang_q == ($past(keypad_lang_in) & `TUM_LANG_MASK))
    else $error("keypad language not taken");

  a_freq_rsvd: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (freq_q & ~`TUM_FREQ_MASK) == 16'h0)
    else $error("reserved frequency bits set");

  a_neutral_hide: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    reg_addr_in == `TUM_OFS_RMS_N && !neutral_sensor_in |=> !reg_valid_out)
    else $error("neutral readable without sensor");
endmodule

// file: tum_master.sv
// Supervisory master model: one register access at a time on the register port
module tum_master (
  // Clock
  input wire logic clock_in,
  // Register port toward the bank
  output tum_pkg::tum_addr_t reg_addr_out,
  output logic reg_wr_out,
  output tum_pkg::tum_word_t reg_wdata_out,
  input wire tum_pkg::tum_word_t reg_rdata_in,
  input wire logic reg_valid_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import tum_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Idle values before the first access
  initial
  begin
    reg_addr_out = 16'h0000;
    reg_wr_out = 1'b0;
    reg_wdata_out = 16'h0000;
  end

  // One-cycle write strobe; data is scrambled afterwards so stale data never helps
  task automatic write_reg(input tum_addr_t a, input tum_word_t d);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge clock_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d;
  endtask

  // Answer launches on the edge that takes the address and is taken at the next edge,
  // so the caller resumes on a rising edge and its stimulus stays edge-aligned
  task automatic read_reg(input tum_addr_t a, output tum_word_t d, output logic v);
    @(posedge clock_in);
    reg_addr_out <= a;
    @(posedge clock_in);
    @(posedge clock_in);
    d = reg_rdata_in;
    v = reg_valid_in;
  endtask
endmodule

// file: tum_regs_test.sv
// Self-checking bench for the measurement register bank
`include "tum_consts.svh"
module tum_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tum_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Stimulus and observation signals, named as the ports
  logic clock_in = 1'b0, rst_n_in = 1'b0, reg_wr_in, reg_valid_out, rotation_prot_en_out;
  logic setting_applied_in = 1'b0, switches_changed_off_in = 1'b1, aux_power_in = 1'b0;
  logic breaker_code_ok_in = 1'b1, fault_trip_in = 1'b0, neutral_sensor_in = 1'b0;
  logic rotation_acb_in = 1'b1, keypad_lang_wr_in = 1'b0;
  tum_addr_t reg_addr_in;
  tum_word_t reg_wdata_in, reg_rdata_out, keypad_lang_in = 16'h0000;
  tum_word_t fault_p1_in = 16'h0064, fault_p2_in = 16'h5000, fault_p3_in = 16'h0001;
  tum_word_t fault_n_in = 16'h0200, rms_p1_in = 16'h0123, rms_p2_in = 16'hFFFF;
  tum_word_t rms_p3_in = 16'h7FFF, rms_n_in = 16'h0456, ground_fault_in = 16'h0010;
  tum_word_t earth_leakage_in = 16'h2710, battery_mv_in = 16'h0000;
  logic [31:0] lt_remaining_in = 32'h0001E240;
  int errors = 0;
  int num_checks = 0;

  // Short tick keeps the once-per-second refresh cheap to simulate
  tum_regs #(.TICK_CYCLES(20)) dut (.clock_in, .rst_n_in, .reg_addr_in, .reg_wr_in,
    .reg_wdata_in, .reg_rdata_out, .reg_valid_out, .setting_applied_in,
    .switches_changed_off_in, .aux_power_in, .breaker_code_ok_in, .fault_trip_in,
    .fault_p1_in, .fault_p2_in, .fault_p3_in, .fault_n_in, .rms_p1_in, .rms_p2_in,
    .rms_p3_in, .rms_n_in, .neutral_sensor_in, .ground_fault_in, .earth_leakage_in,
    .battery_mv_in, .lt_remaining_in, .rotation_acb_in, .keypad_lang_wr_in,
    .keypad_lang_in, .rotation_prot_en_out);

  tum_master m (.clock_in, .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in),
    .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out),
    .reg_valid_in(reg_valid_out));

  // 50 MHz clock
  always #10 clock_in = ~clock_in;

  ////////////////////////////////////////////////////////////////
  // Comparison and access helpers
  task automatic chk(input string n, input tum_word_t e, input tum_word_t g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input tum_addr_t a, input tum_word_t e, input logic ev);
    tum_word_t d;
    logic v;
    m.read_reg(a, d, v);
    chk($sformatf("rdata at %h", a), e, d);
    chk($sformatf("valid at %h", a), {15'h0000, ev}, {15'h0000, v});
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    repeat (5000) @(posedge clock_in);
    errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    tum_addr_t ta[6];
    tum_word_t tv[6];
    tum_word_t bv[4];
    tum_word_t be[4];
    ta = '{`TUM_OFS_RMS_P1, `TUM_OFS_RMS_P2, `TUM_OFS_RMS_P3, `TUM_OFS_GF, `TUM_OFS_EL,
      `TUM_OFS_ROT};
    tv = '{16'h0123, 16'h7FFF, 16'h7FFF, 16'h0010, 16'h2710, 16'h0001};
    bv = '{16'h0AF1, 16'h0AF0, 16'h0899, 16'h0898};
    be = '{16'h0064, 16'h0032, 16'h0032, 16'h0000};
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rd(`TUM_OFS_CHG_CNT, 16'h0001, 1'b1);
    // Back-to-back applied changes, then a write that must be ignored
    setting_applied_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    setting_applied_in <= 1'b0;
    m.write_reg(`TUM_OFS_CHG_CNT, 16'h1234);
    rd(`TUM_OFS_CHG_CNT, 16'h0003, 1'b1);
    // Trip without auxiliary power leaves the no-fault value
    fault_trip_in <= 1'b1;
    @(posedge clock_in);
    fault_trip_in <= 1'b0;
    rd(`TUM_OFS_MAXF_P1, `TUM_NO_FAULT, 1'b1);
    aux_power_in <= 1'b1;
    fault_trip_in <= 1'b1;
    @(posedge clock_in);
    fault_trip_in <= 1'b0;
    lt_remaining_in <= 32'h0000C350;
    rd(`TUM_OFS_MAXF_P1, 16'h0064, 1'b1);
    rd(`TUM_OFS_MAXF_P2, `TUM_FAULT_MAX, 1'b1);
    rd(`TUM_OFS_MAXF_P3, 16'h0001, 1'b1);
    rd(`TUM_OFS_MAXF_N, 16'h0200, 1'b1);
    // Live measurement reads, with clamping of out-of-range inputs
    foreach (ta[i])
      rd(ta[i], tv[i], 1'b1);
    rd(`TUM_OFS_RMS_N, 16'h0000, 1'b0);
    neutral_sensor_in <= 1'b1;
    rd(`TUM_OFS_RMS_N, 16'h0456, 1'b1);
    foreach (bv[i])
    begin
      battery_mv_in <= bv[i];
      rd(`TUM_OFS_BATT, be[i], 1'b1);
    end
    // Remaining time after another trip; refresh needs at least one tick
    repeat (50) @(posedge clock_in);
    rd(`TUM_OFS_LT_HI, 16'h0005, 1'b1);
    rd(`TUM_OFS_LT_LO, 16'h0000, 1'b1);
    lt_remaining_in <= 32'h0001E240;
    repeat (50) @(posedge clock_in);
    rd(`TUM_OFS_LT_HI, 16'h000C, 1'b1);
    rd(`TUM_OFS_LT_LO, 16'h0D80, 1'b1);
    // Language register, remote then keypad
    rd(`TUM_OFS_LANG, `TUM_LANG_RESET, 1'b1);
    m.write_reg(`TUM_OFS_LANG, 16'hFFFF);
    rd(`TUM_OFS_LANG, 16'h03BF, 1'b1);
    keypad_lang_in <= 16'h0080;
    keypad_lang_wr_in <= 1'b1;
    @(posedge clock_in);
    keypad_lang_wr_in <= 1'b0;
    rd(`TUM_OFS_LANG, 16'h0080, 1'b1);
    // Keypad and remote write land on the same edge: keypad wins
    fork
      m.write_reg(`TUM_OFS_LANG, 16'h0001);
      begin
        @(posedge clock_in);
        keypad_lang_in <= 16'h0002;
        keypad_lang_wr_in <= 1'b1;
        @(posedge clock_in);
        keypad_lang_wr_in <= 1'b0;
      end
    join
    rd(`TUM_OFS_LANG, 16'h0002, 1'b1);
    // Frequency selection drives rotation protection enable
    rd(`TUM_OFS_FREQ, `TUM_FREQ_RESET, 1'b1);
    chk("rotation enable", 16'h0001, {15'h0000, rotation_prot_en_out});
    m.write_reg(`TUM_OFS_FREQ, 16'h0008);
    rd(`TUM_OFS_FREQ, 16'h0008, 1'b1);
    chk("rotation enable", 16'h0000, {15'h0000, rotation_prot_en_out});
    m.write_reg(`TUM_OFS_FREQ, 16'hFFFF);
    rd(`TUM_OFS_FREQ, 16'h0009, 1'b1);
    m.write_reg(`TUM_OFS_FREQ, 16'h0001);
    rd(`TUM_OFS_FREQ, 16'h0001, 1'b1);
    chk("rotation enable", 16'h0001, {15'h0000, rotation_prot_en_out});
    // Missing breaker code blocks capture; then larger replaces, smaller keeps
    fault_p1_in <= 16'h0050;
    fault_p3_in <= 16'h0100;
    breaker_code_ok_in <= 1'b0;
    fault_trip_in <= 1'b1;
    @(posedge clock_in);
    fault_trip_in <= 1'b0;
    rd(`TUM_OFS_MAXF_P3, 16'h0001, 1'b1);
    breaker_code_ok_in <= 1'b1;
    fault_trip_in <= 1'b1;
    @(posedge clock_in);
    fault_trip_in <= 1'b0;
    rd(`TUM_OFS_MAXF_P3, 16'h0100, 1'b1);
    rd(`TUM_OFS_MAXF_P1, 16'h0064, 1'b1);
    // Second power-up with untouched switches: no bump, reset values back
    m.write_reg(`TUM_OFS_FREQ, 16'h0008);
    switches_changed_off_in <= 1'b0;
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rd(`TUM_OFS_CHG_CNT, 16'h0000, 1'b1);
    rd(`TUM_OFS_MAXF_P2, `TUM_NO_FAULT, 1'b1);
    rd(`TUM_OFS_LANG, `TUM_LANG_RESET, 1'b1);
    rd(`TUM_OFS_FREQ, `TUM_FREQ_RESET, 1'b1);
    chk("rotation enable", 16'h0001, {15'h0000, rotation_prot_en_out});
    rd(16'h2264, 16'h0000, 1'b0);
    print_verdict();
  end
endmodule
